// ### src/fe_consts.svh
// constants of the front-end line service layer
`ifndef FE_CONSTS_SVH
`define FE_CONSTS_SVH
`define LINE_W 4
// ram select codes of the external access path
`define SEL_CHAR 2'h0
`define SEL_BIT 2'h1
`define SEL_LINE 2'h2
// scanner base control byte bits
`define SBC_START 1
`define SBC_END 2
`define SBC_TRANSP 3
`define SBC_SDLC 4
`define SBC_SS 5
// set mode: single syn reference
`define SM_ONE_SYN 0
// primary control field: apply stacked modem-out
`define PCF_STACK 0
// interrupt request bits
`define IRQ_END 8'h80
`define IRQ_BCC 8'h40
`define IRQ_SYN_TMO 8'h20
`define IRQ_OVERRUN 8'h10
`define IRQ_DRV 8'h04
`define IRQ_MODEM 8'h03
// reset/freeze bits: resets 0..2, freezes 4..6
`define RF_RST_CHAR 0
`define RF_RST_BIT 1
`define RF_RST_LINE 2
`define RF_FRZ_CHAR 4
`define RF_FRZ_BIT 5
`define RF_FRZ_LINE 6
// block check
`define CRC_SDLC_POLY 16'h8408
`define CRC_BSC_POLY 16'hA001
`define CRC_SDLC_INIT 16'hFFFF
`define CRC_SDLC_RES 16'hF0B8
`define MARK_CHAR 8'hFF
// timing
`define CLK_NS 4
`define SEC_NS 1000000000
`define SYN_GAP_S 8'h03
`endif

// ### src/fe_pkg.sv
// types of the front-end line service layer
`include "fe_consts.svh"
package fe_pkg;
  typedef struct packed {
    logic [1:0] ram_sel;
    logic [`LINE_W-1:0] line;
    logic dir;
    logic [1:0] hw;
    logic odd;
  } ram_addr_t;

  typedef struct packed {
    logic we;
    ram_addr_t addr;
    logic [7:0] wdata;
  } ext_req_t;

  typedef struct packed {
    logic write;
    logic [`LINE_W-1:0] line;
    logic dir;
    logic [15:0] addr;
    logic [15:0] data;
  } cs_req_t;

  typedef struct packed {
    logic [`LINE_W-1:0] line;
    logic bit_val;
  } line_bit_t;

  typedef struct packed {
    logic cs_busy;
    cs_req_t cs;
    logic [7:0] rdata;
    logic [15:0] status;
    logic status_valid;
    logic irq;
    logic [7:0] cause;
    logic [`LINE_W-1:0] cause_line;
    line_bit_t tx;
    logic tx_valid;
    logic [7:0] modem_out;
    logic mdir;
    logic [7:0] min_s1;
    logic [7:0] min_s2;
    logic [7:0] echo_s1;
    logic [7:0] echo_s2;
    logic [31:0] tick;
    logic [7:0] sec;
  } fe_state_t;
endpackage

// ### src/front_end_layer.sv
// front-end line service layer: character, bit and line service storages
//
// What this block does
// - control storage transfers go as two-byte cycle-steal bursts
// - normal events and errors raise the level 2 interrupt
// - character ram holds four halfwords per line and direction; hw2 addresses buffers
// - receive keeps old and new characters; transmit keeps both characters of the fetched pair
// - secondary control field is written identically to character and bit rams, except by external writes
// - burst end status is base control byte then secondary control byte
// - interrupt request field is copied into the interrupt cause output
// - receive flags syn gaps of three seconds; transmit inserts syn each second, except in sdlc and start-stop
// - serial field shifts bits in or out, counted by secondary control field
// - receive parallel field holds last assembled character
// - primary control field carries the apply-stacked modem-out bit
// - received characters compare against one or two stored syn references
// - transparent transmit doubles the stored dle character
// - block check cleared per block, accumulated to end, skipped for start-stop
// - sdlc receive expects fixed residue; bsc compares received check bytes
// - transmit appends accumulated block check bytes at block end
// - masked modem-in change sets interrupt bits 0 and 1
// - stacked modem-out applies only when its primary control bit is set
// - masked modem-out compared against echo for driver failure
// - reset/freeze bits reset or freeze each storage separately
`timescale 1ns/100ps
`include "fe_consts.svh"
module front_end_layer #(
  parameter int unsigned SEC_CYCLES = `SEC_NS / `CLK_NS
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ext_valid_i,
  input wire fe_pkg::ext_req_t ext_i,
  output logic ext_ready_o,
  output logic [7:0] ext_rdata_o,
  input wire logic [7:0] rf_i,
  input wire logic bit_valid_i,
  input wire fe_pkg::line_bit_t bit_i,
  input wire logic bit_dir_i,
  output logic bit_ready_o,
  output fe_pkg::line_bit_t tx_o,
  output logic tx_valid_o,
  output logic cs_req_o,
  output fe_pkg::cs_req_t cs_o,
  input wire logic cs_ack_i,
  input wire logic [15:0] cs_rdata_i,
  output logic [15:0] status_o,
  output logic status_valid_o,
  output logic irq_l2_o,
  input wire logic irq_ack_i,
  output logic [7:0] int_cause_o,
  output logic [`LINE_W-1:0] int_line_o,
  input wire logic [`LINE_W-1:0] modem_line_i,
  input wire logic [7:0] modem_in_i,
  input wire logic [7:0] modem_echo_i,
  output logic [7:0] modem_out_o
);
  localparam int DEPTH = 8 << `LINE_W;

  // ----------------------------------------
  // storages and state
  // ----------------------------------------
  logic [15:0] ram_a [DEPTH];
  logic [15:0] ram_b [DEPTH];
  logic [15:0] ram_c [DEPTH];
  fe_pkg::fe_state_t s_ff;
  fe_pkg::fe_state_t nxt_s;
  logic [`LINE_W:0] rec;
  logic [15:0] a [4];
  logic [15:0] b [4];
  logic [15:0] c [4];
  logic [15:0] na [4];
  logic [15:0] nb [4];
  logic [15:0] nc [4];
  logic wr;
  logic sel_cs;
  logic sel_ext;
  logic sel_bit;

  function automatic logic [15:0] crc8(input logic [15:0] cv, input logic [7:0] d,
                                       input logic [15:0] p);
    logic [15:0] r;
    r = cv;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ p) : (r >> 1);
    end
    return r;
  endfunction

  // ----------------------------------------
  // port selection
  // ----------------------------------------
  // one record per cycle keeps the storages single ported
  assign sel_cs = s_ff.cs_busy && cs_ack_i;
  assign sel_ext = !sel_cs && ext_valid_i;
  assign sel_bit = !sel_cs && !ext_valid_i && bit_valid_i;
  assign ext_ready_o = !sel_cs;
  assign bit_ready_o = !sel_cs && !ext_valid_i;

  always_comb begin
    if (sel_cs) begin
      rec = {s_ff.cs.line, s_ff.cs.dir};
    end else if (sel_ext) begin
      rec = {ext_i.addr.line, ext_i.addr.dir};
    end else if (sel_bit) begin
      rec = {bit_i.line, bit_dir_i};
    end else begin
      rec = {modem_line_i, s_ff.mdir};
    end
    for (int k = 0; k < 4; k++) begin
      a[k] = ram_a[{rec, 2'(k)}];
      b[k] = ram_b[{rec, 2'(k)}];
      c[k] = ram_c[{rec, 2'(k)}];
    end
  end

  // ----------------------------------------
  // record update
  // ----------------------------------------
  always_comb begin
    logic [7:0] sbc;
    logic [7:0] secondary_ctl_field;
    logic [7:0] ch;
    logic [15:0] poly;
    logic [15:0] bcc;
    logic [15:0] acc;
    logic sdlc;
    logic ss;
    logic is_syn;
    logic [7:0] chg;
    nxt_s = s_ff;
    na = a;
    nb = b;
    nc = c;
    wr = 1'b0;
    ch = `MARK_CHAR;
    sbc = a[3][15:8];
    secondary_ctl_field = a[0][7:0];
    sdlc = sbc[`SBC_SDLC];
    ss = sbc[`SBC_SS];
    poly = sdlc ? `CRC_SDLC_POLY : `CRC_BSC_POLY;
    bcc = sdlc ? `CRC_SDLC_INIT : 16'h0000;
    acc = c[1];
    is_syn = 1'b0;
    chg = 8'h00;
    nxt_s.status_valid = 1'b0;
    nxt_s.tx_valid = 1'b0;
    nxt_s.min_s1 = modem_in_i;
    nxt_s.min_s2 = s_ff.min_s1;
    nxt_s.echo_s1 = modem_echo_i;
    nxt_s.echo_s2 = s_ff.echo_s1;
    if (s_ff.tick == SEC_CYCLES - 1) begin
      nxt_s.tick = 32'h0;
      nxt_s.sec = s_ff.sec + 8'h01;
    end else begin
      nxt_s.tick = s_ff.tick + 32'h1;
    end
    if (sel_cs) begin
      // burst end: status, buffer address advance, receive block check
      wr = 1'b1;
      nxt_s.cs_busy = 1'b0;
      na[2] = a[2] + 16'h0002;
      if (s_ff.cs.dir) begin
        na[1][15:8] = cs_rdata_i[7:0];
        nb[1][15:8] = cs_rdata_i[15:8];
        secondary_ctl_field[4:3] = 2'b11;
      end else if (sbc[`SBC_END]) begin
        if (!ss && (sdlc ? (acc != `CRC_SDLC_RES) : (acc != 16'h0000))) begin
          na[1][7:0] = na[1][7:0] | `IRQ_BCC;
        end
        na[1][7:0] = na[1][7:0] | `IRQ_END;
        nc[1] = bcc;
        sbc[`SBC_END] = 1'b0;
      end
      nxt_s.status = {a[3][15:8], secondary_ctl_field};
      nxt_s.status_valid = 1'b1;
    end else if (sel_ext) begin
      // byte-wide access to any field of any storage
      unique case (ext_i.addr.ram_sel)
        `SEL_CHAR: ch = ext_i.addr.odd ? a[ext_i.addr.hw][7:0] : a[ext_i.addr.hw][15:8];
        `SEL_BIT: ch = ext_i.addr.odd ? b[ext_i.addr.hw][7:0] : b[ext_i.addr.hw][15:8];
        `SEL_LINE: ch = ext_i.addr.odd ? c[ext_i.addr.hw][7:0] : c[ext_i.addr.hw][15:8];
        default: ch = 8'h00;
      endcase
      nxt_s.rdata = ch;
      if (ext_i.we) begin
        wr = 1'b1;
        unique case ({ext_i.addr.ram_sel, ext_i.addr.odd})
          {`SEL_CHAR, 1'b0}: na[ext_i.addr.hw][15:8] = ext_i.wdata;
          {`SEL_CHAR, 1'b1}: na[ext_i.addr.hw][7:0] = ext_i.wdata;
          {`SEL_BIT, 1'b0}: nb[ext_i.addr.hw][15:8] = ext_i.wdata;
          {`SEL_BIT, 1'b1}: nb[ext_i.addr.hw][7:0] = ext_i.wdata;
          {`SEL_LINE, 1'b0}: nc[ext_i.addr.hw][15:8] = ext_i.wdata;
          {`SEL_LINE, 1'b1}: nc[ext_i.addr.hw][7:0] = ext_i.wdata;
          default: wr = 1'b0;
        endcase
        sbc = na[3][15:8];
        secondary_ctl_field = (ext_i.addr.ram_sel == `SEL_BIT) ? nb[0][7:0] : na[0][7:0];
      end
    end else if (sel_bit && sbc[`SBC_START]) begin
      wr = 1'b1;
      nxt_s.tx.line = bit_i.line;
      if (!bit_dir_i) begin
        // receive: shift in lsb first, whatever the primary control field holds
        ch = {bit_i.bit_val, b[0][15:9]};
        nb[0][15:8] = ch;
        secondary_ctl_field[2:0] = secondary_ctl_field[2:0] + 3'h1;
        if (secondary_ctl_field[2:0] == 3'h0) begin
          nb[1][15:8] = ch;
          if (c[0][8 + `SM_ONE_SYN]) begin
            is_syn = (ch == b[3][15:8]);
          end else begin
            is_syn = (ch == b[3][7:0]) && (b[1][15:8] == b[3][15:8]);
          end
          if (is_syn) begin
            if (secondary_ctl_field[5] && (s_ff.sec - a[3][7:0] >= `SYN_GAP_S)) begin
              na[1][7:0] = na[1][7:0] | `IRQ_SYN_TMO;
            end
            na[3][7:0] = s_ff.sec;
            secondary_ctl_field[5] = 1'b1;
          end else begin
            if (!ss) begin
              nc[1] = crc8(acc, ch, poly);
            end
            if (!secondary_ctl_field[3]) begin
              na[0][15:8] = ch;
              secondary_ctl_field[3] = 1'b1;
            end else begin
              na[1][15:8] = a[0][15:8];
              na[0][15:8] = ch;
              secondary_ctl_field[3] = 1'b0;
              if (s_ff.cs_busy) begin
                na[1][7:0] = na[1][7:0] | `IRQ_OVERRUN;
              end else begin
                nxt_s.cs_busy = 1'b1;
                nxt_s.cs = '{1'b1, bit_i.line, 1'b0, a[2], {a[0][15:8], ch}};
              end
            end
          end
        end
      end else begin
        // transmit: pick a character at each character boundary
        if (secondary_ctl_field[2:0] == 3'h0) begin
          if (secondary_ctl_field[7:6] != 2'b00) begin
            acc = sdlc ? ~c[1] : c[1];
            ch = (secondary_ctl_field[7:6] == 2'b01) ? acc[7:0] : acc[15:8];
            if (secondary_ctl_field[7:6] == 2'b10) begin
              na[1][7:0] = na[1][7:0] | `IRQ_END;
              nc[1] = bcc;
              sbc[`SBC_END] = 1'b0;
              secondary_ctl_field[7:6] = 2'b00;
            end else begin
              secondary_ctl_field[7:6] = 2'b10;
            end
          end else if (!sdlc && !ss && (a[0][15:8] != s_ff.sec)) begin
            ch = b[3][15:8];
            na[0][15:8] = s_ff.sec;
          end else if (secondary_ctl_field[4] && sbc[`SBC_TRANSP] && !secondary_ctl_field[5] && (b[1][15:8] == b[2][15:8])) begin
            ch = b[2][15:8];
            secondary_ctl_field[5] = 1'b1;
          end else if (secondary_ctl_field[4]) begin
            ch = b[1][15:8];
            secondary_ctl_field[5] = 1'b0;
            if (!ss) begin
              nc[1] = crc8(acc, ch, poly);
            end
            if (secondary_ctl_field[3]) begin
              nb[1][15:8] = a[1][15:8];
              secondary_ctl_field[3] = 1'b0;
            end else begin
              secondary_ctl_field[4] = 1'b0;
            end
          end else if (sbc[`SBC_END]) begin
            if (ss) begin
              na[1][7:0] = na[1][7:0] | `IRQ_END;
              sbc[`SBC_END] = 1'b0;
            end else begin
              acc = sdlc ? ~c[1] : c[1];
              ch = acc[7:0];
              secondary_ctl_field[7:6] = 2'b01;
            end
          end
          if (!secondary_ctl_field[4] && !secondary_ctl_field[3] && !sbc[`SBC_END] && !s_ff.cs_busy) begin
            nxt_s.cs_busy = 1'b1;
            nxt_s.cs = '{1'b0, bit_i.line, 1'b1, a[2], 16'h0000};
          end
        end else begin
          ch = b[0][15:8];
        end
        // every character is framed lsb first; the primary control field is not consulted
        nxt_s.tx.bit_val = ch[0];
        nb[0][15:8] = {1'b1, ch[7:1]};
        secondary_ctl_field[2:0] = secondary_ctl_field[2:0] + 3'h1;
        nxt_s.tx_valid = 1'b1;
      end
    end else if (!sel_bit) begin
      // idle cycles watch the modem of the selected line, one direction at a time
      wr = 1'b1;
      nxt_s.mdir = !s_ff.mdir;
      if (!s_ff.mdir) begin
        chg = (s_ff.min_s2 ^ c[2][15:8]) & c[2][7:0];
        if (chg != 8'h00) begin
          nc[2][15:8] = s_ff.min_s2;
          na[1][7:0] = na[1][7:0] | `IRQ_MODEM;
        end
      end else begin
        if (b[1][`PCF_STACK]) begin
          nc[2][15:8] = c[3][15:8];
          nb[1][`PCF_STACK] = 1'b0;
        end
        if (((c[2][15:8] ^ s_ff.echo_s2) & c[2][7:0]) != 8'h00) begin
          na[1][7:0] = na[1][7:0] | `IRQ_DRV;
        end
        nxt_s.modem_out = nc[2][15:8];
      end
    end
    if (!sel_ext) begin
      na[3][15:8] = sbc;
      na[0][7:0] = secondary_ctl_field;
      nb[0][7:0] = secondary_ctl_field;
    end
    // set wins over acknowledge
    if (irq_ack_i) begin
      nxt_s.irq = 1'b0;
    end
    if (wr && ((na[1][7:0] & ~a[1][7:0]) != 8'h00)) begin
      nxt_s.irq = 1'b1;
      nxt_s.cause = na[1][7:0];
      nxt_s.cause_line = rec[`LINE_W:1];
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // a frozen storage keeps its contents unless its reset bit is set; a reset bit clears it while held
  always_ff @(posedge clock_i) begin
    for (int k = 0; k < 4; k++) begin
      if (wr && !rf_i[`RF_FRZ_CHAR]) begin
        ram_a[{rec, 2'(k)}] <= na[k];
      end
      if (wr && !rf_i[`RF_FRZ_BIT]) begin
        ram_b[{rec, 2'(k)}] <= nb[k];
      end
      if (wr && !rf_i[`RF_FRZ_LINE]) begin
        ram_c[{rec, 2'(k)}] <= nc[k];
      end
    end
    for (int j = 0; j < DEPTH; j++) begin
      if (!rst_n_i || rf_i[`RF_RST_CHAR]) begin
        ram_a[j] <= 16'h0000;
      end
      if (!rst_n_i || rf_i[`RF_RST_BIT]) begin
        ram_b[j] <= 16'h0000;
      end
      if (!rst_n_i || rf_i[`RF_RST_LINE]) begin
        ram_c[j] <= 16'h0000;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign ext_rdata_o = s_ff.rdata;
  assign tx_o = s_ff.tx;
  assign tx_valid_o = s_ff.tx_valid;
  assign cs_req_o = s_ff.cs_busy;
  assign cs_o = s_ff.cs;
  assign status_o = s_ff.status;
  assign status_valid_o = s_ff.status_valid;
  assign irq_l2_o = s_ff.irq;
  assign int_cause_o = s_ff.cause;
  assign int_line_o = s_ff.cause_line;
  assign modem_out_o = s_ff.modem_out;
endmodule

// ### dv/front_end_layer_checker.sv
// assertion checker for the front-end line service layer
`timescale 1ns/100ps
`include "fe_consts.svh"
module front_end_layer_checker #(
  parameter int unsigned SEC_CYCLES = 20
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ext_valid_i,
  input wire fe_pkg::ext_req_t ext_i,
  input wire logic ext_ready_o,
  input wire logic [7:0] ext_rdata_o,
  input wire logic [7:0] rf_i,
  input wire logic bit_valid_i,
  input wire fe_pkg::line_bit_t bit_i,
  input wire logic bit_dir_i,
  input wire logic bit_ready_o,
  input wire fe_pkg::line_bit_t tx_o,
  input wire logic tx_valid_o,
  input wire logic cs_req_o,
  input wire fe_pkg::cs_req_t cs_o,
  input wire logic cs_ack_i,
  input wire logic [15:0] cs_rdata_i,
  input wire logic [15:0] status_o,
  input wire logic status_valid_o,
  input wire logic irq_l2_o,
  input wire logic irq_ack_i,
  input wire logic [7:0] int_cause_o,
  input wire logic [`LINE_W-1:0] int_line_o,
  input wire logic [`LINE_W-1:0] modem_line_i,
  input wire logic [7:0] modem_in_i,
  input wire logic [7:0] modem_echo_i,
  input wire logic [7:0] modem_out_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // burst steps
  // ----------------------------------------
  sequence s_ack;
    cs_req_o && cs_ack_i;
  endsequence
  sequence s_done;
    !cs_req_o && status_valid_o;
  endsequence
  a_burst_status: assert property (s_ack |=> s_done)
    else $error("no status after burst ack");
  a_burst_hold: assert property (cs_req_o && !cs_ack_i |=> cs_req_o && $stable(cs_o))
    else $error("burst dropped or changed before ack");
  a_status_cause: assert property (status_valid_o |-> $past(cs_req_o && cs_ack_i))
    else $error("status without burst ack");
  a_ready_ack: assert property (ext_ready_o == !(cs_req_o && cs_ack_i))
    else $error("external path ready wrong");
  a_bit_gate: assert property (bit_ready_o == (ext_ready_o && !ext_valid_i))
    else $error("bit path ready wrong");
  a_tx_cause: assert property (tx_valid_o |->
    $past(bit_valid_i && bit_ready_o && bit_dir_i) && tx_o.line == $past(bit_i.line))
    else $error("tx bit without taken tx event");
  a_irq_hold: assert property (irq_l2_o && !irq_ack_i |=> irq_l2_o)
    else $error("interrupt dropped without ack");
  a_irq_cause: assert property ($rose(irq_l2_o) |-> int_cause_o != 8'h00)
    else $error("interrupt raised with empty cause");
endmodule

// ### dv/scanner_proc_model.sv
// scanner processor model answering cycle-steal bursts
`timescale 1ns/100ps
module scanner_proc_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic [15:0] tx_word_i,
  input wire logic cs_req_i,
  input wire fe_pkg::cs_req_t cs_i,
  output logic cs_ack_o,
  output logic [15:0] cs_rdata_o
);
  int wait_cnt = 0;
  logic go;
  initial begin
    cs_ack_o = 1'b0;
    cs_rdata_o = 16'h0000;
  end
  // one burst outstanding; slow mode stalls five cycles
  assign go = rst_n_i && cs_req_i && !cs_ack_o && (wait_cnt >= (slow_i ? 5 : 0));
  always @(posedge clock_i) begin
    cs_ack_o <= go;
    // data toggles outside the ack cycle so stale reads show up
    cs_rdata_o <= (go && !cs_i.write) ? tx_word_i : ~cs_rdata_o;
    wait_cnt <= (go || !cs_req_i) ? 0 : wait_cnt + 1;
  end
endmodule

// ### dv/line_scanner_front_end_service_bench.sv
// self-checking bench of the front-end line service layer
`timescale 1ns/100ps
`include "fe_consts.svh"
module line_scanner_front_end_service_bench;
  localparam int unsigned SEC_CYCLES = 20;
  logic clock_i, rst_n_i, ext_valid_i, ext_ready_o, bit_valid_i, bit_dir_i, bit_ready_o;
  logic tx_valid_o, cs_req_o, cs_ack_i, status_valid_o, irq_l2_o, irq_ack_i, slow;
  logic [7:0] ext_rdata_o, rf_i, int_cause_o, modem_in_i, modem_echo_i, modem_out_o, c1, c2;
  logic [15:0] cs_rdata_i, status_o, tx_word;
  logic [23:0] tx_sh = 24'hFFFFFF;
  logic [3:0] int_line_o, modem_line_i;
  fe_pkg::ext_req_t ext_i;
  fe_pkg::line_bit_t bit_i, tx_o;
  fe_pkg::cs_req_t cs_o;
  logic [7:0] rd_q[$], st_q[$];
  logic [37:0] cs_q[$];
  logic rd_tk = 1'b0, st_tk = 1'b0, seen = 1'b0;
  int mismatches = 0, n_tests = 0, tx_n = 0;

  front_end_layer #(.SEC_CYCLES(SEC_CYCLES)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .ext_valid_i(ext_valid_i), .ext_i(ext_i), .ext_ready_o(ext_ready_o),
    .ext_rdata_o(ext_rdata_o), .rf_i(rf_i), .bit_valid_i(bit_valid_i), .bit_i(bit_i),
    .bit_dir_i(bit_dir_i), .bit_ready_o(bit_ready_o), .tx_o(tx_o), .tx_valid_o(tx_valid_o),
    .cs_req_o(cs_req_o), .cs_o(cs_o), .cs_ack_i(cs_ack_i), .cs_rdata_i(cs_rdata_i),
    .status_o(status_o), .status_valid_o(status_valid_o), .irq_l2_o(irq_l2_o),
    .irq_ack_i(irq_ack_i), .int_cause_o(int_cause_o), .int_line_o(int_line_o),
    .modem_line_i(modem_line_i), .modem_in_i(modem_in_i), .modem_echo_i(modem_echo_i),
    .modem_out_o(modem_out_o));
  scanner_proc_model u_proc (.clock_i(clock_i), .rst_n_i(rst_n_i), .slow_i(slow),
    .tx_word_i(tx_word), .cs_req_i(cs_req_o), .cs_i(cs_o), .cs_ack_o(cs_ack_i),
    .cs_rdata_o(cs_rdata_i));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask
  task automatic fail(input string m);
    mismatches++;
    $display("Error %0t: %s", $time, m);
    end_of_test();
  endtask
  // request already driven; hold it until sampled with ready high
  task automatic take(input bit is_bit);
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clock_i);
      if ((is_bit ? bit_ready_o : ext_ready_o) === 1'b1) break;
    end
    if (i == 20) fail("handshake stalled");
  endtask
  task automatic ext(input logic we, input logic [1:0] sel, input logic [3:0] ln,
                     input logic d, input logic [2:0] hb, input logic [7:0] wd);
    ext_valid_i <= 1'b1;
    ext_i <= {we, sel, ln, d, hb, wd};
    take(1'b0);
  endtask
  task automatic rd(input logic [1:0] sel, input logic [3:0] ln, input logic d,
                    input logic [2:0] hb, input logic [7:0] exp);
    rd_q.push_back(exp);
    ext(1'b0, sel, ln, d, hb, 8'h00);
  endtask
  task automatic idle(input int n);
    ext_valid_i <= 1'b0;
    bit_valid_i <= 1'b0;
    repeat (n) @(posedge clock_i);
  endtask
  task automatic schar(input logic [3:0] ln, input logic d, input logic [7:0] c);
    for (int k = 0; k < 8; k++) begin
      bit_valid_i <= 1'b1;
      bit_dir_i <= d;
      bit_i <= {ln, c[k]};
      take(1'b1);
    end
  endtask
  task automatic wait_for(input bit modem);
    int i;
    for (i = 0; i < 300; i++) begin
      if (modem ? modem_out_o === 8'hA5 : irq_l2_o === 1'b1) break;
      @(posedge clock_i);
    end
    if (i == 300) fail("wait timed out");
  endtask
  task automatic ack();
    irq_ack_i <= 1'b1;
    @(posedge clock_i);
    irq_ack_i <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask

  // ----------------------------------------
  // result monitor
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (rd_tk) chk(ext_rdata_o, rd_q.pop_front(), "read byte");
    if (st_tk) chk(status_o[15:8], st_q.pop_front(), "status byte");
    if (cs_req_o && cs_ack_i && cs_q.size() > 0) chk(cs_o, cs_q.pop_front(), "burst");
    rd_tk <= rst_n_i && ext_valid_i && ext_ready_o && !ext_i.we;
    st_tk <= cs_req_o && cs_ack_i && st_q.size() > 0;
    if (tx_valid_o && tx_o.line == 4'h3) begin
      tx_sh <= {tx_o.bit_val, tx_sh[23:1]};
      tx_n <= tx_n + 1;
    end
    // idle mark first, then the fetched pair in halfword order, lsb first
    if (tx_n == 24) seen <= (tx_sh == {tx_word[7:0], tx_word[15:8], `MARK_CHAR});
  end

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  initial begin
    logic [15:0] a;
    logic [7:0] b;
    rst_n_i = 1'b0; ext_valid_i = 1'b0; ext_i = '0; rf_i = 8'h00; bit_valid_i = 1'b0;
    bit_i = '0; bit_dir_i = 1'b0; irq_ack_i = 1'b0; modem_line_i = 4'hF;
    modem_in_i = 8'h00; modem_echo_i = 8'h00; slow = 1'b0; tx_word = 16'h0000;
    void'($urandom(32'h39C2));
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    chk({irq_l2_o, cs_req_o, status_valid_o, tx_valid_o}, 0, "outputs after reset");
    // every byte of line 1, both directions, in every storage, back to back write then read
    for (int i = 0; i < 64; i++) begin
      b = 8'($urandom);
      ext(1'b1, i[5:4], 4'h1, i[3], i[2:0], b);
      rd(i[5:4], 4'h1, i[3], i[2:0], (i[5:4] == 2'h3) ? 8'h00 : b);
    end
    ext(1'b1, `SEL_CHAR, 4'h1, 1'b0, 3'h4, 8'h3C);
    idle(1);
    rf_i <= 8'h10;
    idle(2);
    ext(1'b1, `SEL_CHAR, 4'h1, 1'b0, 3'h4, 8'hC3);
    rd(`SEL_CHAR, 4'h1, 1'b0, 3'h4, 8'h3C);
    idle(1);
    rf_i <= 8'h02;
    idle(2);
    rf_i <= 8'h00;
    idle(2);
    rd(`SEL_BIT, 4'h1, 1'b0, 3'h2, 8'h00);
    rd(`SEL_CHAR, 4'h1, 1'b0, 3'h4, 8'h3C);
    idle(2);
    $display("storage test done");
    // receive two characters into one slow burst
    a = 16'($urandom);
    // nonzero: a zero would match the cleared syn references
    c1 = {1'b0, 7'($urandom)} | 8'h01;
    c2 = 8'($urandom);
    tx_word <= {c1, c2};
    ext(1'b1, `SEL_CHAR, 4'h2, 1'b0, 3'h4, a[15:8]);
    ext(1'b1, `SEL_CHAR, 4'h2, 1'b0, 3'h5, a[7:0]);
    ext(1'b1, `SEL_CHAR, 4'h2, 1'b0, 3'h6, 8'h22);
    idle(1);
    slow <= 1'b1;
    cs_q.push_back({1'b1, 4'h2, 1'b0, a, c1, c2});
    st_q.push_back(8'h22);
    schar(4'h2, 1'b0, c1);
    schar(4'h2, 1'b0, c2);
    idle(40);
    chk(cs_q.size() + st_q.size(), 0, "receive burst");
    $display("receive test done");
    // transmit: fetched pair must come out lsb first
    ext(1'b1, `SEL_CHAR, 4'h3, 1'b1, 3'h4, a[15:8]);
    ext(1'b1, `SEL_CHAR, 4'h3, 1'b1, 3'h5, a[7:0]);
    ext(1'b1, `SEL_CHAR, 4'h3, 1'b1, 3'h6, 8'h22);
    idle(1);
    slow <= 1'b0;
    for (int i = 0; i < 8; i++) schar(4'h3, 1'b1, 8'h00);
    idle(4);
    chk(seen, 1'b1, "transmit characters");
    $display("transmit test done");
    // modem change masked, then unmasked
    ack();
    modem_line_i <= 4'h4;
    ext(1'b1, `SEL_LINE, 4'h4, 1'b0, 3'h4, 8'h00);
    ext(1'b1, `SEL_LINE, 4'h4, 1'b0, 3'h5, 8'h00);
    idle(1);
    modem_in_i <= 8'hC3;
    idle(30);
    chk(irq_l2_o, 1'b0, "masked modem change");
    ext(1'b1, `SEL_LINE, 4'h4, 1'b0, 3'h5, 8'hFF);
    idle(1);
    wait_for(1'b0);
    chk(|(int_cause_o & `IRQ_MODEM), 1'b1, "modem change cause");
    chk(int_line_o, 4'h4, "cause line");
    ack();
    chk(irq_l2_o, 1'b0, "interrupt cleared");
    // stacked modem-out waits for its control bit; then driver check
    ext(1'b1, `SEL_LINE, 4'h4, 1'b1, 3'h6, 8'hA5);
    idle(30);
    chk(modem_out_o, 8'h00, "stacked pattern held");
    ext(1'b1, `SEL_BIT, 4'h4, 1'b1, 3'h3, 8'h01);
    idle(1);
    wait_for(1'b1);
    chk(modem_out_o, 8'hA5, "stacked pattern applied");
    ext(1'b1, `SEL_LINE, 4'h4, 1'b1, 3'h5, 8'hFF);
    idle(1);
    wait_for(1'b0);
    chk(|(int_cause_o & `IRQ_DRV), 1'b1, "driver check cause");
    $display("modem test done");
    end_of_test();
  end
endmodule

bind front_end_layer front_end_layer_checker #(.SEC_CYCLES(SEC_CYCLES)) u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .ext_valid_i(ext_valid_i), .ext_i(ext_i),
  .ext_ready_o(ext_ready_o), .ext_rdata_o(ext_rdata_o), .rf_i(rf_i),
  .bit_valid_i(bit_valid_i), .bit_i(bit_i), .bit_dir_i(bit_dir_i), .bit_ready_o(bit_ready_o),
  .tx_o(tx_o), .tx_valid_o(tx_valid_o), .cs_req_o(cs_req_o), .cs_o(cs_o),
  .cs_ack_i(cs_ack_i), .cs_rdata_i(cs_rdata_i), .status_o(status_o),
  .status_valid_o(status_valid_o), .irq_l2_o(irq_l2_o), .irq_ack_i(irq_ack_i),
  .int_cause_o(int_cause_o), .int_line_o(int_line_o), .modem_line_i(modem_line_i),
  .modem_in_i(modem_in_i), .modem_echo_i(modem_echo_i), .modem_out_o(modem_out_o));
